// ===== agc_cfg_pkg.sv
package agc_cfg_pkg;
   // register offsets within a page
   localparam logic [7:0] PAGE_SELECT_OFS  = 8'h00;
   localparam logic [7:0] DECAY_OFS        = 8'h6a;
   localparam logic [7:0] ADC_PATH_OFS     = 8'h6b;
   localparam logic [7:0] BYPASS_OFS       = 8'h6c;
   localparam logic [7:0] REG_RESET        = 8'h00;
   // field positions
   localparam int DECAY_SEL_BIT   = 7;
   localparam int BASE_MSB        = 6;
   localparam int BASE_LSB        = 5;
   localparam int MULT_MSB        = 4;
   localparam int MULT_LSB        = 2;
   localparam int HPF_LEFT_BIT    = 7;
   localparam int HPF_RIGHT_BIT   = 6;
   localparam int DECIM_MSB       = 5;
   localparam int DECIM_LSB       = 4;
   localparam int FILT_PATH_BIT   = 3;
   localparam int DETECT_OFF_BIT  = 2;
   localparam int BUS_ERR_BIT     = 0;
   localparam int LINE_SW_BIT     = 5;
   localparam int PAGE_BIT        = 0;
   // writable masks: adc path bits 1..0 are read-only
   localparam logic [7:0] ADC_PATH_WMASK = 8'hfc;
   // baseline decay times, in milliseconds
   localparam logic [15:0] BASE_MS_0 = 16'h0032;  // 50 ms
   localparam logic [15:0] BASE_MS_1 = 16'h0096;  // 150 ms
   localparam logic [15:0] BASE_MS_2 = 16'h00fa;  // 250 ms
   localparam logic [15:0] BASE_MS_3 = 16'h015e;  // 350 ms
   // decay ceilings in milliseconds, indexed by twice the clock ratio
   localparam logic [15:0] CAP_MS_R1   = 16'h0fa0;  // 4000 ms
   localparam logic [15:0] CAP_MS_R1H  = 16'h15e0;  // 5600 ms
   localparam logic [15:0] CAP_MS_R2   = 16'h1f40;  // 8000 ms
   localparam logic [15:0] CAP_MS_R2H  = 16'h2580;  // 9600 ms
   localparam logic [15:0] CAP_MS_R3   = 16'h2bc0;  // 11200 ms
   localparam logic [15:0] CAP_MS_R4   = 16'h3e80;  // 16000 ms
   localparam logic [15:0] CAP_MS_R5   = 16'h4b00;  // 19200 ms
   localparam logic [15:0] CAP_MS_R5H  = 16'h5780;  // 22400 ms
   // decimation filter microphone mix
   typedef enum logic [1:0] {
      MIC_BOTH_DIGITAL = 2'h0,
      MIC_L_DIG_R_ANA  = 2'h1,
      MIC_L_ANA_R_DIG  = 2'h2,
      MIC_BOTH_ANALOG  = 2'h3
   } mic_cfg_t;
   // one register access from the serial control bus front end
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } bus_req_t;
   // decay field set handed to the calculator
   typedef struct packed {
      logic [1:0] base;
      logic [2:0] mult;
      logic [3:0] ratioHalf;
   } decay_cfg_t;
endpackage : agc_cfg_pkg

// ===== decay_time_calc.sv
`timescale 1ns/10ps
// effective decay = baseline times power-of-two factor, capped by clock ratio
module decay_time_calc (
   input  wire logic                     ref_clk,  // processing clock
   input  wire logic                     sys_rst,  // synchronous reset
   input  wire agc_cfg_pkg::decay_cfg_t  cfg,      // decay fields and ratio
   output logic [15:0]                   decayMs   // capped decay time in ms
);
   import agc_cfg_pkg::*;

   logic [15:0] baseMs;
   logic [15:0] capMs;
   logic [15:0] product;
   logic [15:0] next_decayMs;

   // baseline lookup and ratio ceiling
   always_comb
   begin
      unique case (cfg.base)
         2'h0: baseMs = BASE_MS_0;
         2'h1: baseMs = BASE_MS_1;
         2'h2: baseMs = BASE_MS_2;
         2'h3: baseMs = BASE_MS_3;
      endcase
      // ratios up to 1 take the tightest ceiling, from 5.5 up the loosest
      case (cfg.ratioHalf)
         4'h0, 4'h1, 4'h2: capMs = CAP_MS_R1;
         4'h3:             capMs = CAP_MS_R1H;
         4'h4:             capMs = CAP_MS_R2;
         4'h5:             capMs = CAP_MS_R2H;
         4'h6, 4'h7:       capMs = CAP_MS_R3;
         4'h8, 4'h9:       capMs = CAP_MS_R4;
         4'ha:             capMs = CAP_MS_R5;
         default:          capMs = CAP_MS_R5H;
      endcase
   end

   // 350 ms shifted by 7 still fits in 16 bits
   assign product = baseMs << cfg.mult;
   assign next_decayMs = (product > capMs) ? capMs : product;

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         decayMs <= BASE_MS_0;
      else
         decayMs <= next_decayMs;
   end

   a_decay_product: assert property (@(posedge ref_clk) disable iff (sys_rst)
      ((BASE_MS_0 << cfg.mult) <= CAP_MS_R1 && cfg.base == 2'h0)
      |=> decayMs == (BASE_MS_0 << $past(cfg.mult)))
      else $error("decay is not baseline times factor");
   a_decay_cap: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (cfg.ratioHalf == 4'h2 && cfg.mult == 3'h7) |=> decayMs == CAP_MS_R1)
      else $error("decay not capped at ratio one");
   a_decay_top: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (cfg.ratioHalf == 4'hc && cfg.base == 2'h3 && cfg.mult == 3'h7)
      |=> decayMs == CAP_MS_R5H)
      else $error("decay not capped at ratio six");
endmodule : decay_time_calc

// ===== agc_decay_adc_path_config_regs.sv
`timescale 1ns/10ps
module agc_decay_adc_path_config_regs (
   input  wire logic                   ref_clk,            // 25 MHz processing clock
   input  wire logic                   sys_rst,            // synchronous reset, active high
   input  wire agc_cfg_pkg::bus_req_t  busReq,             // register access from bus front end
   output logic [7:0]                  rdData,             // read data, valid cycle after rd
   input  wire logic                   busErrorEvent,      // one-cycle bus error seen by front end
   input  wire logic                   dacsPoweredDown,    // both dacs are powered down
   input  wire logic [15:0]            legacyDecayMs,      // decay time from legacy agc register
   input  wire logic [3:0]             codecRatioHalf,     // codec_clock_ratio times two
   output logic [15:0]                 rightDecayMs,       // right agc decay time in ms
   output logic                        hpfLeftProg,        // left hpf uses programmable coeffs
   output logic                        hpfRightProg,       // right hpf uses programmable coeffs
   output agc_cfg_pkg::mic_cfg_t       decimCfg,           // decimation microphone mix
   output logic                        progFilterOnAdc,    // programmable filter on adc output
   output logic                        busRecoverPulse,    // clear bus error condition, one cycle
   output logic                        lineSwitchClosed,   // first_right_negative_line_input switch
   output logic                        activePage          // 0: page 0, 1: page 1
);
   import agc_cfg_pkg::*;

   logic [7:0]  decayReg;
   logic [7:0]  adcPathReg;
   logic [7:0]  bypassReg;
   logic        pageReg;
   logic        busErrStatus;
   logic [7:0]  next_decayReg;
   logic [7:0]  next_adcPathReg;
   logic [7:0]  next_bypassReg;
   logic        next_pageReg;
   logic        next_busErrStatus;
   logic [7:0]  next_rdData;
   logic [15:0] newDecayMs;
   logic [15:0] next_rightDecayMs;
   logic        next_busRecoverPulse;
   logic        onPage0;
   logic        detectEn;
   logic        errSeen;
   logic        statusRead;
   decay_cfg_t  decayCfg;

   assign onPage0  = ~pageReg;
   assign detectEn = ~adcPathReg[DETECT_OFF_BIT];
   assign errSeen  = busErrorEvent & detectEn;
   assign statusRead = busReq.rd & onPage0 & (busReq.addr == ADC_PATH_OFS);

   // decay calculator sees the new programmable fields
   assign decayCfg.base      = decayReg[BASE_MSB:BASE_LSB];
   assign decayCfg.mult      = decayReg[MULT_MSB:MULT_LSB];
   assign decayCfg.ratioHalf = codecRatioHalf;

   decay_time_calc u_decay (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .cfg     (decayCfg),
      .decayMs (newDecayMs)
   );

   // register writes; page select lives at offset 0 on both pages
   always_comb
   begin
      next_decayReg   = decayReg;
      next_adcPathReg = adcPathReg;
      next_bypassReg  = bypassReg;
      next_pageReg    = pageReg;
      if (busReq.wr)
      begin
         if (busReq.addr == PAGE_SELECT_OFS)
            next_pageReg = busReq.wdata[PAGE_BIT];
         else if (onPage0 && busReq.addr == DECAY_OFS)
            next_decayReg = busReq.wdata;  // reserved bits kept as written
         else if (onPage0 && busReq.addr == ADC_PATH_OFS)
            next_adcPathReg = busReq.wdata & ADC_PATH_WMASK;
         else if (onPage0 && busReq.addr == BYPASS_OFS)
            next_bypassReg = busReq.wdata;  // upper reserved bits kept as written
      end
   end

   // sticky error: a new error wins over the clearing read in the same cycle
   always_comb
   begin
      next_busErrStatus = busErrStatus;
      if (statusRead)
         next_busErrStatus = 1'b0;
      if (errSeen)
         next_busErrStatus = 1'b1;
      next_busRecoverPulse = errSeen;
   end

   // read mux; unmapped offsets and page 1 answer zero, except the page select at offset 0
   always_comb
   begin
      next_rdData = rdData;
      if (busReq.rd)
      begin
         next_rdData = REG_RESET;
         if (busReq.addr == PAGE_SELECT_OFS)
            next_rdData[PAGE_BIT] = pageReg;
         else if (onPage0 && busReq.addr == DECAY_OFS)
            next_rdData = decayReg;
         else if (onPage0 && busReq.addr == ADC_PATH_OFS)
         begin
            next_rdData = adcPathReg;
            next_rdData[BUS_ERR_BIT] = busErrStatus;
         end
         else if (onPage0 && busReq.addr == BYPASS_OFS)
            next_rdData = bypassReg;
      end
   end

   // decay source select: legacy register or the new fields
   assign next_rightDecayMs = decayReg[DECAY_SEL_BIT] ? newDecayMs : legacyDecayMs;

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         decayReg        <= REG_RESET;
         adcPathReg      <= REG_RESET;
         bypassReg       <= REG_RESET;
         pageReg         <= 1'b0;
         busErrStatus    <= 1'b0;
         rdData          <= REG_RESET;
         rightDecayMs    <= BASE_MS_0;
         busRecoverPulse <= 1'b0;
      end
      else
      begin
         decayReg        <= next_decayReg;
         adcPathReg      <= next_adcPathReg;
         bypassReg       <= next_bypassReg;
         pageReg         <= next_pageReg;
         busErrStatus    <= next_busErrStatus;
         rdData          <= next_rdData;
         rightDecayMs    <= next_rightDecayMs;
         busRecoverPulse <= next_busRecoverPulse;
      end
   end

   // path controls straight from the stored bits, except the filter path, which is gated by dacsPoweredDown
   assign hpfLeftProg  = adcPathReg[HPF_LEFT_BIT];
   assign hpfRightProg = adcPathReg[HPF_RIGHT_BIT];
   assign decimCfg     = mic_cfg_t'(adcPathReg[DECIM_MSB:DECIM_LSB]);
   // the dacs share the filter engine, so it only serves the adc when they sleep
   assign progFilterOnAdc  = adcPathReg[FILT_PATH_BIT] & dacsPoweredDown;
   assign lineSwitchClosed = bypassReg[LINE_SW_BIT];
   assign activePage       = pageReg;

   a_status_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (busErrorEvent && detectEn) |=> busErrStatus ##0 busRecoverPulse)
      else $error("error status not set by detected error");
   a_status_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (statusRead && !busErrorEvent) |=> !busErrStatus)
      else $error("error status not cleared by read");
   a_detect_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!sys_rst && !detectEn && !statusRead) |=> $stable(busErrStatus) && !busRecoverPulse)
      else $error("error detected while detector disabled");
   a_hpf_select: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (busReq.wr && onPage0 && busReq.addr == ADC_PATH_OFS)
      |=> hpfLeftProg == $past(busReq.wdata[HPF_LEFT_BIT])
          && hpfRightProg == $past(busReq.wdata[HPF_RIGHT_BIT]))
      else $error("high-pass coefficient select not taken");
   a_decim_cfg: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (busReq.wr && onPage0 && busReq.addr == ADC_PATH_OFS)
      |=> decimCfg == $past(busReq.wdata[DECIM_MSB:DECIM_LSB]))
      else $error("decimation config not taken");
   a_filter_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !dacsPoweredDown |-> !progFilterOnAdc)
      else $error("filter attached while a dac is powered");
   a_line_switch: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (busReq.wr && onPage0 && busReq.addr == BYPASS_OFS)
      |=> lineSwitchClosed == $past(busReq.wdata[LINE_SW_BIT]))
      else $error("bypass switch not updated");
   a_page_select: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (busReq.wr && busReq.addr == PAGE_SELECT_OFS)
      |=> activePage == $past(busReq.wdata[PAGE_BIT]))
      else $error("page select not taken");
   // reset drops by a non-blocking write on an edge, so that edge's attempt is not disabled
   a_legacy_src: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!sys_rst && !decayReg[DECAY_SEL_BIT]) |=> rightDecayMs == $past(legacyDecayMs))
      else $error("legacy decay not used");
   // same-cycle error and clearing read: the error must not be lost
   a_set_wins: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (statusRead && errSeen) |=> busErrStatus)
      else $error("error lost to a clearing read");
   a_status_readout: assert property (@(posedge ref_clk) disable iff (sys_rst)
      statusRead |=> rdData[BUS_ERR_BIT] == $past(busErrStatus))
      else $error("read did not return error status");
   a_new_src: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!sys_rst && decayReg[DECAY_SEL_BIT]) |=> rightDecayMs == $past(newDecayMs))
      else $error("new decay fields not used");
   a_filter_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !adcPathReg[FILT_PATH_BIT] |-> !progFilterOnAdc)
      else $error("filter attached with path bit clear");
   a_page1_reads: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (busReq.rd && pageReg && busReq.addr != PAGE_SELECT_OFS) |=> rdData == REG_RESET)
      else $error("page 1 read returned page 0 data");

   c_error_read: cover property (@(posedge ref_clk) disable iff (sys_rst)
      busErrStatus ##1 statusRead ##1 !busErrStatus);
   c_set_and_read: cover property (@(posedge ref_clk) disable iff (sys_rst)
      statusRead && errSeen);
   c_new_decay: cover property (@(posedge ref_clk) disable iff (sys_rst)
      decayReg[DECAY_SEL_BIT] && decayReg[MULT_MSB:MULT_LSB] == 3'h7);
   c_filter_on: cover property (@(posedge ref_clk) disable iff (sys_rst) progFilterOnAdc);
endmodule : agc_decay_adc_path_config_regs

// ===== host_ctrl_model.sv
`timescale 1ns/10ps
// control bus host: one access at a time, bus released between accesses
module host_ctrl_model (
   input  wire logic             ref_clk, // processing clock
   output agc_cfg_pkg::bus_req_t busReq,  // access toward the register bank
   input  wire logic [7:0]       rdData   // read data from the register bank
);
   import agc_cfg_pkg::*;
   initial busReq = '0;
   // released bus shows inverted address and data, so stale values never look valid
   task automatic release_bus();
      busReq <= '{wr: 1'b0, rd: 1'b0, addr: ~busReq.addr, wdata: ~busReq.wdata};
   endtask : release_bus
   // request held for one edge, then released on the next
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      logic [7:0] d;
      d = data;
      if (addr == DECAY_OFS) d[1:0] = 2'h0; // reserved bits written as zero
      if (addr == BYPASS_OFS) d[7:6] = 2'h0; // reserved bits written as zero
      @(posedge ref_clk);
      busReq <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: d};
      @(posedge ref_clk);
      release_bus();
   endtask : write_reg
   // data is taken mid-cycle after the edge that accepted the read
   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
      @(posedge ref_clk);
      busReq <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
      @(posedge ref_clk);
      release_bus();
      @(negedge ref_clk);
      data = rdData;
   endtask : read_reg
   // the page bit is read back after each change
   task automatic set_page(input logic pg, output logic [7:0] back);
      write_reg(PAGE_SELECT_OFS, {7'h00, pg});
      read_reg(PAGE_SELECT_OFS, back);
   endtask : set_page
endmodule : host_ctrl_model

// ===== tb.sv
`timescale 1ns/10ps
module tb;
   import agc_cfg_pkg::*;
   logic        ref_clk, sys_rst, busErrorEvent, dacsPoweredDown;
   logic        hpfLeftProg, hpfRightProg, progFilterOnAdc, busRecoverPulse;
   logic        lineSwitchClosed, activePage;
   logic [3:0]  codecRatioHalf;
   logic [7:0]  rdData, rd;
   logic [15:0] legacyDecayMs, rightDecayMs;
   bus_req_t    busReq;
   mic_cfg_t    decimCfg;
   int          miscompares, nTests, expMs;
   logic [15:0] baseMs [4] = '{BASE_MS_0, BASE_MS_1, BASE_MS_2, BASE_MS_3};
   logic [15:0] capMs [16] = '{CAP_MS_R1, CAP_MS_R1, CAP_MS_R1, CAP_MS_R1H, CAP_MS_R2,
      CAP_MS_R2H, CAP_MS_R3, CAP_MS_R3, CAP_MS_R4, CAP_MS_R4, CAP_MS_R5, CAP_MS_R5H,
      CAP_MS_R5H, CAP_MS_R5H, CAP_MS_R5H, CAP_MS_R5H};
   agc_decay_adc_path_config_regs agc_decay_adc_path_config_regs_i (.ref_clk(ref_clk),
      .sys_rst(sys_rst), .busReq(busReq), .rdData(rdData), .busErrorEvent(busErrorEvent),
      .dacsPoweredDown(dacsPoweredDown), .legacyDecayMs(legacyDecayMs),
      .codecRatioHalf(codecRatioHalf), .rightDecayMs(rightDecayMs),
      .hpfLeftProg(hpfLeftProg), .hpfRightProg(hpfRightProg), .decimCfg(decimCfg),
      .progFilterOnAdc(progFilterOnAdc), .busRecoverPulse(busRecoverPulse),
      .lineSwitchClosed(lineSwitchClosed), .activePage(activePage));
   host_ctrl_model host_ctrl_model_i (.ref_clk(ref_clk), .busReq(busReq), .rdData(rdData));
   // 25 MHz clock
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      nTests++;
      if (got !== exp)
      begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         miscompares++;
      end
   endtask : chk
   task automatic wrapUp();
      if (miscompares == 0 && nTests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrapUp
   // decay path needs two edges after a change; no spare edge is allowed
   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask : settle
   // error event is one cycle wide, recovery pulse looked at in the following cycle
   task automatic err_pulse(input logic expPulse);
      @(posedge ref_clk) busErrorEvent <= 1'b1;
      @(posedge ref_clk) busErrorEvent <= 1'b0;
      @(negedge ref_clk);
      chk("busRecoverPulse", 16'(expPulse), 16'(busRecoverPulse));
   endtask : err_pulse
   // a hang is cut short well past the few hundred cycles the sequence takes
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      wrapUp();
   end
   // main sequence
   initial
   begin
      sys_rst = 1'b1;
      busErrorEvent = 1'b0;
      dacsPoweredDown = 1'b0;
      legacyDecayMs = 16'h04d2;
      codecRatioHalf = 4'hc;
      repeat (12) @(posedge ref_clk);
      sys_rst <= 1'b0;
      foreach (baseMs[k])
      begin
         host_ctrl_model_i.read_reg(8'h6a + 8'(k), rd);
         chk("reset value", 16'(REG_RESET), 16'(rd)); // offset 0x6d is unmapped
      end
      chk("legacy decay", 16'h04d2, rightDecayMs);
      for (int b = 0; b < 4; b++)
         for (int m = 0; m < 8; m++)
         begin
            host_ctrl_model_i.write_reg(DECAY_OFS, 8'(8'h80 | (b << 5) | (m << 2)));
            settle(2);
            expMs = int'(baseMs[b]) << m;
            if (expMs > int'(CAP_MS_R5H)) expMs = int'(CAP_MS_R5H);
            chk("decay", 16'(expMs), rightDecayMs);
         end
      for (int r = 0; r < 16; r++)
      begin
         @(posedge ref_clk) codecRatioHalf <= 4'(r);
         settle(2);
         chk("decay cap", capMs[r], rightDecayMs);
      end
      host_ctrl_model_i.write_reg(DECAY_OFS, 8'h7c);
      settle(2);
      chk("legacy again", 16'h04d2, rightDecayMs);
      for (int i = 0; i < 4; i++)
      begin
         @(posedge ref_clk) dacsPoweredDown <= i[0];
         host_ctrl_model_i.write_reg(ADC_PATH_OFS, 8'(8'h08 | (i << 4) | (i << 6)));
         settle(0);
         chk("hpfLeftProg", 16'(i[1]), 16'(hpfLeftProg));
         chk("hpfRightProg", 16'(i[0]), 16'(hpfRightProg));
         chk("decimCfg", 16'(i[1:0]), 16'(decimCfg));
         chk("progFilterOnAdc", 16'(i[0]), 16'(progFilterOnAdc));
      end
      host_ctrl_model_i.write_reg(ADC_PATH_OFS, 8'h00);
      settle(0);
      chk("progFilterOnAdc off", 16'h0000, 16'(progFilterOnAdc));
      err_pulse(1'b1);
      host_ctrl_model_i.read_reg(ADC_PATH_OFS, rd);
      chk("error status set", 16'h0001, 16'(rd));
      host_ctrl_model_i.read_reg(ADC_PATH_OFS, rd);
      chk("error status cleared", 16'h0000, 16'(rd));
      // an error in the very cycle of the clearing read must survive it
      fork
         host_ctrl_model_i.read_reg(ADC_PATH_OFS, rd);
         err_pulse(1'b1);
      join
      chk("status read with error", 16'h0000, 16'(rd));
      host_ctrl_model_i.read_reg(ADC_PATH_OFS, rd);
      chk("set wins over read", 16'h0001, 16'(rd));
      host_ctrl_model_i.write_reg(ADC_PATH_OFS, 8'hff);
      err_pulse(1'b0);
      host_ctrl_model_i.read_reg(ADC_PATH_OFS, rd);
      chk("detector off", 16'(ADC_PATH_WMASK), 16'(rd));
      for (int k = 0; k < 2; k++)
      begin
         host_ctrl_model_i.write_reg(BYPASS_OFS, 8'(8'hdf | (k << 5)));
         settle(0);
         chk("lineSwitchClosed", 16'(k), 16'(lineSwitchClosed));
      end
      host_ctrl_model_i.set_page(1'b1, rd);
      chk("page readback", 16'h0001, 16'(rd));
      chk("activePage", 16'h0001, 16'(activePage));
      host_ctrl_model_i.write_reg(BYPASS_OFS, 8'h00);
      host_ctrl_model_i.read_reg(BYPASS_OFS, rd);
      chk("page 1 bypass", 16'h0000, 16'(rd));
      host_ctrl_model_i.set_page(1'b0, rd);
      chk("activePage back", 16'h0000, 16'(activePage));
      host_ctrl_model_i.read_reg(BYPASS_OFS, rd);
      chk("bypass kept", 16'h003f, 16'(rd));
      @(posedge ref_clk) sys_rst <= 1'b1;
      @(posedge ref_clk) sys_rst <= 1'b0;
      host_ctrl_model_i.read_reg(BYPASS_OFS, rd);
      chk("second reset", 16'(REG_RESET), 16'(rd));
      wrapUp();
   end
endmodule : tb
